// *** srb_device.sv ***
// special register bank: byte and bit access, fixed bits, flash views
`timescale 1ns/1ns

// Overview of operation
// R1 - core never touches undefined register addresses
// R2 - each register used only for its function
// R3 - reserved bits written zero, read undefined
// R4 - fixed-zero bits written zero, read zero
// R5 - fixed-one bits written one, read one
// R6 - bit addressable registers reachable bit by bit
// R7 - flash address reads status, writes command
// R8 - flash status view resets to 70 hex
// R9 - twowire status: code high, low three zero
// R10 - data pointer built from high and low
// R11 - read-only writes ignored, unmapped reads zero (here a twowire status write discards a same-cycle tw_stat_load)
module srb_device import srb_pkg::*; (
	input  wire logic        pclk,            // core clock
	input  wire logic        presetn,         // async reset, low
	srb_if.dev               core,            // register access link
	input  wire logic        tw_stat_load,    // new twowire status
	input  wire logic [4:0]  tw_stat_code,    // twowire status code
	input  wire logic        tw_event,        // sets twowire event flag
	input  wire logic [1:0]  cmp_flag_set,    // comparator change flags
	input  wire logic        fl_stat_load,    // new flash status
	input  wire logic        fl_busy,         // flash operation running
	input  wire logic        fl_hva,          // high voltage abort
	input  wire logic        fl_hve,          // high voltage error
	input  wire logic        fl_sv,           // security violation
	input  wire logic        fl_oi,           // operation interrupted
	output logic [15:0]      data_pointer_pair,      // 16-bit pointer
	output logic [7:0]       core_clock_divider,     // clock divider
	output logic [7:0]       auxiliary_function,     // aux control
	output logic [7:0]       interrupt_enable_low,   // enables low
	output logic [7:0]       interrupt_enable_high,  // enables high
	output logic [7:0]       interrupt_priority_low, // priority low
	output logic [7:0]       comparator_one_control, // comparator 1
	output logic [7:0]       comparator_two_control, // comparator 2
	output logic [7:0]       baud_gen_control,       // baud control
	output logic [15:0]      baud_gen_rate,          // baud divisor
	output logic [7:0]       twowire_control,        // twowire control
	output logic [7:0]       twowire_data,           // twowire data
	output logic [7:0]       twowire_own_address,    // own address
	output logic [7:0]       twowire_clock_low,      // scl low time
	output logic [7:0]       twowire_clock_high,     // scl high time
	output logic [7:0]       arith_main_operand,     // accumulator
	output logic [7:0]       multiply_aux_operand,   // aux operand
	output logic [7:0]       flash_data_byte,        // flash data
	output logic [15:0]      flash_address,          // flash address
	output logic [7:0]       flash_command_code,     // last command
	output logic             flash_command_stb,      // command pulse
	output logic             soft_reset_stb          // soft reset pulse
);
	// ****************************************
	// register slots
	// ****************************************
	localparam logic [4:0] IX_DPL   = 5'(srb_index(`SRB_ADR_DPL));
	localparam logic [4:0] IX_DPH   = 5'(srb_index(`SRB_ADR_DPH));
	localparam logic [4:0] IX_CORE_CLOCK_DIVIDER  = 5'(srb_index(`SRB_ADR_CORE_CLOCK_DIVIDER));
	localparam logic [4:0] IX_AUX   = 5'(srb_index(`SRB_ADR_AUX));
	localparam logic [4:0] IX_IENL  = 5'(srb_index(`SRB_ADR_IENL));
	localparam logic [4:0] IX_COMPARATOR_ONE_CONTROL  = 5'(srb_index(`SRB_ADR_COMPARATOR_ONE_CONTROL));
	localparam logic [4:0] IX_COMPARATOR_TWO_CONTROL  = 5'(srb_index(`SRB_ADR_COMPARATOR_TWO_CONTROL));
	localparam logic [4:0] IX_IPL   = 5'(srb_index(`SRB_ADR_IPL));
	localparam logic [4:0] IX_BRGC  = 5'(srb_index(`SRB_ADR_BRGC));
	localparam logic [4:0] IX_BRGL  = 5'(srb_index(`SRB_ADR_BRGL));
	localparam logic [4:0] IX_BRGH  = 5'(srb_index(`SRB_ADR_BRGH));
	localparam logic [4:0] IX_TWC   = 5'(srb_index(`SRB_ADR_TWCTL));
	localparam logic [4:0] IX_TWS   = 5'(srb_index(`SRB_ADR_TWSTAT));
	localparam logic [4:0] IX_TWD   = 5'(srb_index(`SRB_ADR_TWDAT));
	localparam logic [4:0] IX_TWA   = 5'(srb_index(`SRB_ADR_TWADR));
	localparam logic [4:0] IX_TWL   = 5'(srb_index(`SRB_ADR_TWSCLL));
	localparam logic [4:0] IX_TWH   = 5'(srb_index(`SRB_ADR_TWSCLH));
	localparam logic [4:0] IX_ACC   = 5'(srb_index(`SRB_ADR_ACC));
	localparam logic [4:0] IX_FMC   = 5'(srb_index(`SRB_ADR_FLCTL));
	localparam logic [4:0] IX_FMD   = 5'(srb_index(`SRB_ADR_FLDAT));
	localparam logic [4:0] IX_FAL   = 5'(srb_index(`SRB_ADR_FLADL));
	localparam logic [4:0] IX_FAH   = 5'(srb_index(`SRB_ADR_FLADH));
	localparam logic [4:0] IX_IENH  = 5'(srb_index(`SRB_ADR_IENH));
	localparam logic [4:0] IX_B     = 5'(srb_index(`SRB_ADR_BREG));

	srb_dev_t   st_reg;
	srb_dev_t   st_next;
	logic [7:0] bm_byte;
	logic [2:0] bm_bit;
	logic       bm_ok;
	logic [7:0] tgt;
	logic [5:0] slot;
	logic       hit;
	logic [7:0] cur;
	logic [7:0] wmask;

	// ****************************************
	// address decode
	// ****************************************
	srb_bitmap u_bitmap (
		.bit_addr  (core.addr),
		.byte_addr (bm_byte),
		.bit_pos   (bm_bit),
		.bit_ok    (bm_ok)
	);

	assign tgt  = core.bit_op ? bm_byte : core.addr;             // [R6]
	assign slot = srb_index(tgt);
	assign hit  = slot[5] && (!core.bit_op || bm_ok);            // [R11]
	// fixed bits are forced on the read path, whatever is stored
	assign cur  = (st_reg.r[slot[4:0]] & ~srb_zero(tgt))         // [R4]
		| srb_ones(tgt);                                         // [R5]

	// status views take no software data; reserved and fixed bits
	// keep their stored value so reserved reads stay stable
	always_comb begin
		if (tgt == `SRB_ADR_TWSTAT || tgt == `SRB_ADR_FLCTL)
			wmask = 8'h00;                                       // [R11]
		else
			wmask = ~(srb_rsv(tgt) | srb_zero(tgt) | srb_ones(tgt)); // [R3]
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [7:0] nv;
		nv = core.wdata;
		st_next = st_reg;
		st_next.ack  = 1'b0;
		st_next.fstb = 1'b0;
		st_next.srst = 1'b0;
		if (tw_stat_load)
			st_next.r[IX_TWS] = {tw_stat_code, 3'b000};          // [R9]
		if (fl_stat_load)
			st_next.r[IX_FMC] = {fl_busy, st_reg.r[IX_FMC][6:4],
				fl_hva, fl_hve, fl_sv, fl_oi};                   // [R7]
		if (core.req) begin
			st_next.ack   = 1'b1;
			st_next.rdata = 8'h00;                               // [R11]
			if (hit && !core.wr) begin
				if (core.bit_op)
					st_next.rdata = {7'h00, cur[bm_bit]};        // [R6]
				else
					st_next.rdata = cur;
			end else if (hit && tgt == `SRB_ADR_FLCTL) begin
				// command path only; status view is left untouched
				st_next.fcmd = core.wdata;                       // [R7]
				st_next.fstb = 1'b1;
			end else if (hit) begin
				if (core.bit_op) begin
					nv = cur;
					nv[bm_bit] = core.wdata[0];                  // [R6]
				end
				st_next.r[slot[4:0]] = (st_reg.r[slot[4:0]] & ~wmask)
					| (nv & wmask);                              // [R11]
				if (tgt == `SRB_ADR_AUX && nv[`SRB_AUX_SRST]) begin
					st_next.srst = 1'b1;
					// self-clearing: a stored one would re-fire later
					st_next.r[IX_AUX][`SRB_AUX_SRST] = 1'b0;
				end
			end
		end
		// hardware sets come last so a same-cycle clear loses
		if (tw_event)
			st_next.r[IX_TWC][`SRB_TWC_SI] = 1'b1;
		if (cmp_flag_set[0])
			st_next.r[IX_COMPARATOR_ONE_CONTROL][`SRB_CMP_FLAG] = 1'b1;
		if (cmp_flag_set[1])
			st_next.r[IX_COMPARATOR_TWO_CONTROL][`SRB_CMP_FLAG] = 1'b1;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.r[IX_TWS] <= `SRB_RST_TWSTAT;                 // [R9]
			st_reg.r[IX_FMC] <= `SRB_RST_FLSTAT;                 // [R8]
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign core.ack   = st_reg.ack;
	assign core.rdata = st_reg.rdata;

	assign data_pointer_pair = {st_reg.r[IX_DPH], st_reg.r[IX_DPL]}; // [R10]
	assign core_clock_divider     = st_reg.r[IX_CORE_CLOCK_DIVIDER];
	assign auxiliary_function     = st_reg.r[IX_AUX];
	assign interrupt_enable_low   = st_reg.r[IX_IENL];
	assign interrupt_enable_high  = st_reg.r[IX_IENH];
	assign interrupt_priority_low = st_reg.r[IX_IPL];
	assign comparator_one_control = st_reg.r[IX_COMPARATOR_ONE_CONTROL];
	assign comparator_two_control = st_reg.r[IX_COMPARATOR_TWO_CONTROL];
	assign baud_gen_control       = st_reg.r[IX_BRGC];
	assign baud_gen_rate          = {st_reg.r[IX_BRGH], st_reg.r[IX_BRGL]};
	assign twowire_control        = st_reg.r[IX_TWC];
	assign twowire_data           = st_reg.r[IX_TWD];
	assign twowire_own_address    = st_reg.r[IX_TWA];
	assign twowire_clock_low      = st_reg.r[IX_TWL];
	assign twowire_clock_high     = st_reg.r[IX_TWH];
	assign arith_main_operand     = st_reg.r[IX_ACC];
	assign multiply_aux_operand   = st_reg.r[IX_B];
	assign flash_data_byte        = st_reg.r[IX_FMD];
	assign flash_address          = {st_reg.r[IX_FAH], st_reg.r[IX_FAL]};
	assign flash_command_code     = st_reg.fcmd;
	assign flash_command_stb      = st_reg.fstb;
	assign soft_reset_stb         = st_reg.srst;
endmodule

// *** srb_cfg.svh ***
// register map constants for the special register bank and its core master
`ifndef SRB_CFG_SVH
`define SRB_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define SRB_NREG        24
`define SRB_ADR_DPL     8'h82
`define SRB_ADR_DPH     8'h83
`define SRB_ADR_CORE_CLOCK_DIVIDER    8'h95
`define SRB_ADR_AUX     8'hA2
`define SRB_ADR_IENL    8'hA8
`define SRB_ADR_COMPARATOR_ONE_CONTROL    8'hAC
`define SRB_ADR_COMPARATOR_TWO_CONTROL    8'hAD
`define SRB_ADR_IPL     8'hB8
`define SRB_ADR_BRGC    8'hBD
`define SRB_ADR_BRGL    8'hBE
`define SRB_ADR_BRGH    8'hBF
`define SRB_ADR_TWCTL   8'hD8
`define SRB_ADR_TWSTAT  8'hD9
`define SRB_ADR_TWDAT   8'hDA
`define SRB_ADR_TWADR   8'hDB
`define SRB_ADR_TWSCLL  8'hDC
`define SRB_ADR_TWSCLH  8'hDD
`define SRB_ADR_ACC     8'hE0
`define SRB_ADR_FLCTL   8'hE4
`define SRB_ADR_FLDAT   8'hE5
`define SRB_ADR_FLADL   8'hE6
`define SRB_ADR_FLADH   8'hE7
`define SRB_ADR_IENH    8'hE8
`define SRB_ADR_BREG    8'hF0

// ****************************************
// reset values, bit masks, field positions
// ****************************************
`define SRB_RST_TWSTAT  8'hF8
`define SRB_RST_FLSTAT  8'h70
`define SRB_RSV_AUX     8'h02
`define SRB_RSV_BRGC    8'hFC
`define SRB_RSV_CMP     8'hC0
`define SRB_RSV_TWCTL   8'h82
`define SRB_RSV_IENH    8'hB8
`define SRB_RSV_IPL     8'h80
`define SRB_RSV_FLCTL   8'h70
`define SRB_ZERO_AUX    8'h04
`define SRB_ZERO_TWSTAT 8'h07
`define SRB_ONES_NONE   8'h00
`define SRB_AUX_SRST    3
`define SRB_TWC_SI      3
`define SRB_CMP_FLAG    0

// ****************************************
// core master registers (APB side)
// ****************************************
`define SRB_H_CMD       8'h00
`define SRB_H_STAT      8'h04
`define SRB_CMD_WR      16
`define SRB_CMD_BIT     17
`define SRB_ST_BUSY     0
`define SRB_ST_DONE     1
`define SRB_ST_ERR      2

`endif

// *** srb_pkg.sv ***
// types and map helpers shared by both ends of the register bank link
package srb_pkg;
`include "srb_cfg.svh"

	localparam logic [`SRB_NREG-1:0][7:0] SRB_MAP = {
		`SRB_ADR_BREG, `SRB_ADR_IENH, `SRB_ADR_FLADH, `SRB_ADR_FLADL,
		`SRB_ADR_FLDAT, `SRB_ADR_FLCTL, `SRB_ADR_ACC, `SRB_ADR_TWSCLH,
		`SRB_ADR_TWSCLL, `SRB_ADR_TWADR, `SRB_ADR_TWDAT, `SRB_ADR_TWSTAT,
		`SRB_ADR_TWCTL, `SRB_ADR_BRGH, `SRB_ADR_BRGL, `SRB_ADR_BRGC,
		`SRB_ADR_IPL, `SRB_ADR_COMPARATOR_TWO_CONTROL, `SRB_ADR_COMPARATOR_ONE_CONTROL, `SRB_ADR_IENL,
		`SRB_ADR_AUX, `SRB_ADR_CORE_CLOCK_DIVIDER, `SRB_ADR_DPH, `SRB_ADR_DPL};

	typedef enum logic [1:0] {
		SRB_H_IDLE  = 2'b00,
		SRB_H_ISSUE = 2'b01,
		SRB_H_WAIT  = 2'b11
	} srb_hstate_t;

	typedef struct packed {
		logic [`SRB_NREG-1:0][7:0] r;
		logic                      ack;
		logic [7:0]                rdata;
		logic [7:0]                fcmd;
		logic                      fstb;
		logic                      srst;
	} srb_dev_t;

	typedef struct packed {
		srb_hstate_t fsm;
		logic        req;
		logic        wr;
		logic        bit_op;
		logic [7:0]  addr;
		logic [7:0]  wdata;
		logic        busy;
		logic        done;
		logic        err;
		logic [7:0]  rdata;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} srb_host_t;

	// bit 5 flags a mapped address, bits 4:0 give its slot
	function automatic logic [5:0] srb_index(input logic [7:0] a);
		srb_index = 6'h00;
		for (int i = 0; i < `SRB_NREG; i++)
			if (SRB_MAP[i] == a)
				srb_index = {1'b1, 5'(i)};
	endfunction

	function automatic logic srb_bit_ok(input logic [7:0] a);
		srb_bit_ok = (a == `SRB_ADR_ACC) || (a == `SRB_ADR_BREG) ||
			(a == `SRB_ADR_TWCTL) || (a == `SRB_ADR_IENL) ||
			(a == `SRB_ADR_IENH) || (a == `SRB_ADR_IPL);
	endfunction

	function automatic logic [7:0] srb_rsv(input logic [7:0] a);
		if (a == `SRB_ADR_AUX) srb_rsv = `SRB_RSV_AUX;
		else if (a == `SRB_ADR_BRGC) srb_rsv = `SRB_RSV_BRGC;
		else if (a == `SRB_ADR_COMPARATOR_ONE_CONTROL) srb_rsv = `SRB_RSV_CMP;
		else if (a == `SRB_ADR_COMPARATOR_TWO_CONTROL) srb_rsv = `SRB_RSV_CMP;
		else if (a == `SRB_ADR_TWCTL) srb_rsv = `SRB_RSV_TWCTL;
		else if (a == `SRB_ADR_IENH) srb_rsv = `SRB_RSV_IENH;
		else if (a == `SRB_ADR_IPL) srb_rsv = `SRB_RSV_IPL;
		else srb_rsv = 8'h00;
	endfunction

	function automatic logic [7:0] srb_zero(input logic [7:0] a);
		if (a == `SRB_ADR_AUX) srb_zero = `SRB_ZERO_AUX;
		else if (a == `SRB_ADR_TWSTAT) srb_zero = `SRB_ZERO_TWSTAT;
		else srb_zero = 8'h00;
	endfunction

	// no fixed-one positions exist in this map yet; kept for derivatives
	function automatic logic [7:0] srb_ones(input logic [7:0] a);
		srb_ones = (a == 8'h00) ? 8'h00 : `SRB_ONES_NONE;
	endfunction
endpackage

// *** srb_if.sv ***
// core-side register access link between the bank and its master
`timescale 1ns/1ns
interface srb_if;
	logic       req;
	logic       wr;
	logic       bit_op;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       ack;

	modport dev  (input req, wr, bit_op, addr, wdata, output rdata, ack);
	modport core (output req, wr, bit_op, addr, wdata, input rdata, ack);
endinterface

// *** srb_bitmap.sv ***
// splits a bit address into its owning register and bit position
`timescale 1ns/1ns
module srb_bitmap import srb_pkg::*; (
	input  wire logic [7:0] bit_addr,   // bit address from the core
	output logic      [7:0] byte_addr,  // owning register address
	output logic      [2:0] bit_pos,    // bit inside that register
	output logic            bit_ok      // register is bit addressable
);
	// ****************************************
	// bit address split
	// ****************************************
	always_comb begin
		byte_addr = {bit_addr[7:3], 3'b000};
		bit_pos   = bit_addr[2:0];
		bit_ok    = srb_bit_ok(byte_addr);
	end
endmodule

// *** srb_host.sv ***
// core-side master: APB command registers drive single register accesses
`timescale 1ns/1ns
module srb_host import srb_pkg::*; (
	input  wire logic        pclk,     // APB clock
	input  wire logic        presetn,  // async reset, low
	input  wire logic [7:0]  paddr,    // APB byte address
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB access phase
	input  wire logic        pwrite,   // APB direction
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error
	srb_if.core              core      // register access link
);
	srb_host_t  st_reg;
	srb_host_t  st_next;
	logic       fin;
	logic       start;
	logic [7:0] tgt;
	logic [7:0] fix;
	logic [5:0] tslot;
	logic       legal;

	// ****************************************
	// command check
	// ****************************************
	// access is committed on the edge that completes the transfer
	assign fin   = psel && penable && st_reg.pready;
	assign start = fin && pwrite && paddr == `SRB_H_CMD;
	assign tgt   = pwdata[`SRB_CMD_BIT] ? {pwdata[7:3], 3'b000}
		: pwdata[7:0];
	assign fix   = srb_rsv(tgt) | srb_zero(tgt) | srb_ones(tgt);
	assign tslot = srb_index(tgt);
	assign legal = tslot[5]                                      // [R1]
		&& (!pwdata[`SRB_CMD_BIT] || srb_bit_ok(tgt))
		&& !(pwdata[`SRB_CMD_BIT] && pwdata[`SRB_CMD_WR]
		&& fix[pwdata[2:0]]);                                    // [R3]

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.req    = 1'b0;
		st_next.pready = 1'b0;
		if (psel && penable && !st_reg.pready) begin
			st_next.pready  = 1'b1;
			st_next.pslverr = !(paddr == `SRB_H_CMD
				|| paddr == `SRB_H_STAT);
			if (paddr == `SRB_H_STAT)
				st_next.prdata = {16'h0000, st_reg.rdata, 5'h00,
					st_reg.err, st_reg.done, st_reg.busy};
			else if (paddr == `SRB_H_CMD)
				st_next.prdata = {14'h0000, st_reg.bit_op, st_reg.wr,
					st_reg.wdata, st_reg.addr};
			else
				st_next.prdata = 32'h0000_0000;
		end
		case (st_reg.fsm)
			SRB_H_IDLE: begin
				// commands arriving while busy are dropped
				if (start && !legal) begin
					st_next.err  = 1'b1;                         // [R1]
					st_next.done = 1'b0;
				end else if (start) begin
					st_next.addr   = pwdata[7:0];
					st_next.wr     = pwdata[`SRB_CMD_WR];
					st_next.bit_op = pwdata[`SRB_CMD_BIT];
					// the flash command byte is passed unshaped
					if (pwdata[`SRB_CMD_BIT]
						|| tgt == `SRB_ADR_FLCTL)
						st_next.wdata = pwdata[15:8];            // [R2]
					else
						st_next.wdata = (pwdata[15:8] & ~(srb_rsv(tgt)
							| srb_zero(tgt))) | srb_ones(tgt);   // [R4] [R5]
					st_next.req  = 1'b1;
					st_next.busy = 1'b1;
					st_next.done = 1'b0;
					st_next.err  = 1'b0;
					st_next.fsm  = SRB_H_ISSUE;
				end
			end
			SRB_H_ISSUE: st_next.fsm = SRB_H_WAIT;
			SRB_H_WAIT: begin
				if (core.ack) begin
					st_next.rdata = core.rdata;
					st_next.busy  = 1'b0;
					st_next.done  = 1'b1;
					st_next.fsm   = SRB_H_IDLE;
				end
			end
			default: st_next.fsm = SRB_H_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata      = st_reg.prdata;
	assign pready      = st_reg.pready;
	assign pslverr     = st_reg.pslverr;
	assign core.req    = st_reg.req;
	assign core.wr     = st_reg.wr;
	assign core.bit_op = st_reg.bit_op;
	assign core.addr   = st_reg.addr;
	assign core.wdata  = st_reg.wdata;
endmodule

// *** srb_props.sv ***
// assertions on the register access link between host and bank
`timescale 1ns/1ns
module srb_props (
	input wire logic       pclk,    // core clock
	input wire logic       presetn, // async reset, low
	input wire logic       req,     // access request
	input wire logic       wr,      // write when high
	input wire logic       bit_op,  // bit access when high
	input wire logic [7:0] addr,    // register or bit address
	input wire logic [7:0] wdata,   // write byte
	input wire logic [7:0] rdata,   // read answer
	input wire logic       ack      // answer strobe
);
	// ****************************************
	// accumulator shadow
	// ****************************************
	logic [7:0] acc_reg;
	logic [7:0] acc_next;
	logic       acc_bit;

	// no hardware source writes the accumulator, so core writes predict it
	always_comb begin
		acc_next = acc_reg;
		if (req && wr && !bit_op && addr == 8'hE0)
			acc_next = wdata;
		else if (req && wr && bit_op && addr[7:3] == 5'h1C)
			acc_next[addr[2:0]] = wdata[0];
		acc_bit = acc_reg[addr[2:0]];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acc_reg <= 8'h00;
		else
			acc_reg <= acc_next;
	end

	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_rd(logic [7:0] a);
		req && !wr && !bit_op && addr == a;
	endsequence
	sequence s_bit_rd_acc;
		req && !wr && bit_op && addr[7:3] == 5'h1C;
	endsequence

	property p_ack_next; req |=> ack; endproperty
	property p_ack_cause; ack |-> $past(req); endproperty
	property p_req_gap; req |=> !req; endproperty
	property p_aux_zero; s_rd(8'hA2) |=> rdata[2] == 1'b0; endproperty
	property p_tw_low; s_rd(8'hD9) |=> rdata[2:0] == 3'b000; endproperty
	property p_fl_ones; s_rd(8'hE4) |=> rdata[6:4] == 3'b111; endproperty
	property p_acc_byte; s_rd(8'hE0) |=> rdata == $past(acc_reg); endproperty
	property p_acc_bit; s_bit_rd_acc |=> rdata[0] == $past(acc_bit); endproperty

	a_ack_next: assert property (p_ack_next)
		else $error("ack missing one cycle after req");
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without a request");
	a_req_gap: assert property (p_req_gap)
		else $error("request repeated before ack");
	a_aux_zero: assert property (p_aux_zero)
		else $error("aux fixed-zero bit read as one");
	a_tw_low: assert property (p_tw_low)
		else $error("twowire status low bits not zero");
	a_fl_ones: assert property (p_fl_ones)
		else $error("flash status bits 6:4 not set");
	a_acc_byte: assert property (p_acc_byte)
		else $error("accumulator byte read mismatch");
	a_acc_bit: assert property (p_acc_bit)
		else $error("accumulator bit read mismatch");
endmodule

// *** tb.sv ***
// self-checking bench: APB host drives the bank across the link
`timescale 1ns/1ns
`include "srb_cfg.svh"
module tb import srb_pkg::*; ;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tw_stat_load = 1'b0;
	logic [4:0]  tw_stat_code = 5'h00;
	logic        tw_event = 1'b0;
	logic [1:0]  cmp_flag_set = 2'b00;
	logic        fl_stat_load = 1'b0;
	logic        fl_busy = 1'b0;
	logic        fl_hva = 1'b0;
	logic        fl_hve = 1'b0;
	logic        fl_sv = 1'b0;
	logic        fl_oi = 1'b0;
	logic [15:0] dp;
	logic [7:0]  fcmd;
	logic [7:0]  bop;
	logic        fstb;
	logic        sstb;
	logic [7:0]  q;
	logic        e;
	logic        perr;
	logic [7:0]  acc;
	logic [31:0] pr;
	int          errors = 0;
	int          check_count = 0;
	int          fc_n = 0;
	int          sr_n = 0;
	int          cyc = 0;

	srb_if u_srb_if ();
	srb_host u_srb_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core(u_srb_if.core));
	srb_device u_srb_device (.pclk(pclk), .presetn(presetn),
		.core(u_srb_if.dev), .tw_stat_load(tw_stat_load),
		.tw_stat_code(tw_stat_code), .tw_event(tw_event),
		.cmp_flag_set(cmp_flag_set), .fl_stat_load(fl_stat_load),
		.fl_busy(fl_busy), .fl_hva(fl_hva), .fl_hve(fl_hve), .fl_sv(fl_sv),
		.fl_oi(fl_oi), .data_pointer_pair(dp), .core_clock_divider(),
		.auxiliary_function(), .interrupt_enable_low(),
		.interrupt_enable_high(), .interrupt_priority_low(),
		.comparator_one_control(), .comparator_two_control(),
		.baud_gen_control(), .baud_gen_rate(), .twowire_control(),
		.twowire_data(), .twowire_own_address(), .twowire_clock_low(),
		.twowire_clock_high(), .arith_main_operand(acc),
		.multiply_aux_operand(bop), .flash_data_byte(), .flash_address(),
		.flash_command_code(fcmd), .flash_command_stb(fstb),
		.soft_reset_stb(sstb));
	srb_props u_srb_props (.pclk(pclk), .presetn(presetn),
		.req(u_srb_if.req), .wr(u_srb_if.wr), .bit_op(u_srb_if.bit_op),
		.addr(u_srb_if.addr), .wdata(u_srb_if.wdata),
		.rdata(u_srb_if.rdata), .ack(u_srb_if.ack));

	always #25 pclk = ~pclk;

	// ****************************************
	// tasks
	// ****************************************
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// pulses are counted here since they stand for one cycle only
	always @(posedge pclk) begin
		cyc++;
		if (fstb === 1'b1) fc_n++;
		if (sstb === 1'b1) sr_n++;
		if (cyc == 5000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [7:0] ex, got);
		check_count++;
		if (got !== ex) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// pready and prdata are read as they stood just before the edge;
	// only the cycle ceiling ends a wait that never completes
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic op(input logic w, b, input logic [7:0] a, d,
			output logic [7:0] rq, output logic re);
		logic [31:0] r;
		apb(1'b1, `SRB_H_CMD, {14'h0, b, w, d, a}, r);
		do begin
			apb(1'b0, `SRB_H_STAT, 32'h0, r);
		end while (r[1] !== 1'b1 && r[2] !== 1'b1);
		rq = r[15:8];
		re = r[2];
	endtask

	task automatic wr(input logic b, input logic [7:0] a, d);
		op(1'b1, b, a, d, q, e);
	endtask

	task automatic rd_chk(input logic b, input logic [7:0] a, ex, string nm);
		op(1'b0, b, a, 8'h00, q, e);
		chk(nm, ex, q);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < `SRB_NREG; i++) begin
			op(1'b0, 1'b0, SRB_MAP[i], 8'h00, q, e);
			chk("reset value", SRB_MAP[i] == `SRB_ADR_TWSTAT ? 8'hF8 :
				SRB_MAP[i] == `SRB_ADR_FLCTL ? 8'h70 : 8'h00, q);
		end
		$display("test reset values done");
		wr(1'b0, 8'h83, 8'h12);
		wr(1'b0, 8'h82, 8'h34);
		chk("pointer high", 8'h12, dp[15:8]);
		chk("pointer low", 8'h34, dp[7:0]);
		wr(1'b0, 8'hA2, 8'hFF);
		rd_chk(1'b0, 8'hA2, 8'hF1, "aux function");
		chk("soft reset pulses", 8'h01, 8'(sr_n));
		wr(1'b0, 8'hBD, 8'hFF);
		rd_chk(1'b0, 8'hBD, 8'h03, "baud control");
		wr(1'b0, 8'hD9, 8'h00);
		rd_chk(1'b0, 8'hD9, 8'hF8, "status after write");
		$display("test fixed bits done");
		wr(1'b1, 8'hE3, 8'h01);
		wr(1'b1, 8'hE7, 8'h01);
		rd_chk(1'b0, 8'hE0, 8'h88, "accumulator");
		chk("accumulator port", 8'h88, acc);
		op(1'b0, 1'b1, 8'hE3, 8'h00, q, e);
		chk("accumulator bit", 8'h01, {7'h00, q[0]});
		wr(1'b1, 8'hF7, 8'h01);
		chk("aux operand", 8'h80, bop);
		op(1'b0, 1'b1, 8'h83, 8'h00, q, e);
		chk("bit refusal", 8'h01, {7'h00, e});
		op(1'b0, 1'b0, 8'h90, 8'h00, q, e);
		chk("unmapped refusal", 8'h01, {7'h00, e});
		$display("test bit access done");
		@(posedge pclk);
		fl_busy <= 1'b1;
		fl_hva <= 1'b1;
		fl_sv <= 1'b1;
		fl_oi <= 1'b1;
		fl_stat_load <= 1'b1;
		@(posedge pclk);
		fl_stat_load <= 1'b0;
		rd_chk(1'b0, 8'hE4, 8'hFB, "flash status");
		wr(1'b0, 8'hE4, 8'hA5);
		chk("flash command", 8'hA5, fcmd);
		chk("command pulses", 8'h01, 8'(fc_n));
		rd_chk(1'b0, 8'hE4, 8'hFB, "status after command");
		$display("test flash views done");
		@(posedge pclk);
		tw_stat_code <= 5'h0A;
		tw_stat_load <= 1'b1;
		tw_event <= 1'b1;
		cmp_flag_set <= 2'b11;
		@(posedge pclk);
		tw_stat_load <= 1'b0;
		tw_event <= 1'b0;
		cmp_flag_set <= 2'b00;
		rd_chk(1'b0, 8'hD9, 8'h50, "twowire status code");
		rd_chk(1'b0, 8'hD8, 8'h08, "twowire event flag");
		rd_chk(1'b0, 8'hAC, 8'h01, "comparator one flag");
		rd_chk(1'b0, 8'hAD, 8'h01, "comparator two flag");
		$display("test unit status done");
		apb(1'b0, `SRB_H_CMD, 32'h0, pr);
		chk("command readback", 8'hAD, pr[7:0]);
		apb(1'b0, 8'h08, 32'h0, pr);
		chk("bad offset error", 8'h01, {7'h00, perr});
		chk("bad offset data", 8'h00, pr[7:0]);
		$display("test host registers done");
		wrap_up();
	end
endmodule
